// File: rtc_pkg.sv
// Package for the real-time clock divider, rate and control block
package rtc_pkg;

  localparam int unsigned PADDR_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_DIV_RATE = 8'h0a;
  localparam logic [7:0] IDX_CTRL     = 8'h0b;
  localparam logic [7:0] IDX_FLAGS    = 8'h0c;

  // Divider/rate/status register fields
  localparam int unsigned A_PENDING_BIT = 7;
  localparam int unsigned A_DIVSEL_LSB  = 4;
  localparam int unsigned A_RATESEL_LSB = 0;
  // Control register fields
  localparam int unsigned B_SET_BIT  = 7;
  localparam int unsigned B_PIE_BIT  = 6;
  localparam int unsigned B_AIE_BIT  = 5;
  localparam int unsigned B_UIE_BIT  = 4;
  localparam int unsigned B_SQUARE_WAVE_EN_BIT = 3;
  localparam int unsigned B_BIN_BIT  = 2;
  localparam int unsigned B_H24_BIT  = 1;
  localparam int unsigned B_DSE_BIT  = 0;
  // Flag register fields
  localparam int unsigned C_REQUEST_SUMMARY_FLAG_BIT = 7;
  localparam int unsigned C_FLAG_LSB = 4;

  // Divider select codes and stage bypass counts
  localparam logic [2:0] DIV_FAST  = 3'h0;
  localparam logic [2:0] DIV_MID   = 3'h1;
  localparam logic [2:0] DIV_SLOW  = 3'h2;
  localparam logic [2:0] DIV_HOLDA = 3'h6;
  localparam logic [2:0] DIV_HOLDB = 3'h7;
  localparam int unsigned BYPASS_FAST = 0;
  localparam int unsigned BYPASS_MID  = 2;
  localparam int unsigned BYPASS_SLOW = 7;
  localparam int unsigned DIV_W = 22;
  localparam logic [DIV_W-1:0] DIV_HALF = 22'h200000;

  // Tap offsets: tap bit = rate code + offset
  localparam logic [4:0] TAP_OFS_FAST = 5'h05;
  localparam logic [4:0] TAP_OFS_SLOW = 5'h0c;
  localparam logic [3:0] RATE_SPLIT   = 4'h3;

  // Timing
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned PRE_UPDATE_US   = 244;
  localparam int unsigned UPDATE_FAST_US  = 248;
  localparam int unsigned UPDATE_SLOW_US  = 1984;
  localparam int unsigned PRE_UPDATE_CYC_DEF  = PRE_UPDATE_US * CLK_MHZ;
  localparam int unsigned UPDATE_FAST_CYC_DEF = UPDATE_FAST_US * CLK_MHZ;
  localparam int unsigned UPDATE_SLOW_CYC_DEF = UPDATE_SLOW_US * CLK_MHZ;
  localparam int unsigned UPD_CNT_W = 18;

  // Power-on values of the selects, which the reset pin leaves alone, and of the control register
  localparam logic [3:0] POR_RATESEL = 4'h0;
  localparam logic [2:0] POR_DIVSEL  = 3'h6;
  localparam logic [7:0] POR_CTRL    = 8'h80;

  typedef enum logic [1:0] {UPD_IDLE, UPD_PENDING, UPD_BUSY} upd_state_t;

  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } time_t;

  typedef struct packed {
    logic advance;
    logic binaryFmt;
    logic hour24;
    logic dstEn;
    logic holdSet;
  } cal_ctl_t;

endpackage

// File: rtc_divider_rate_and_control.sv
// Divider chain, rate taps, update timing and control/flag registers of the clock
`timescale 1ns/1ps
module rtc_divider_rate_and_control
  import rtc_pkg::*;
#(
  parameter int unsigned PRE_UPDATE_CYC  = PRE_UPDATE_CYC_DEF,
  parameter int unsigned UPDATE_FAST_CYC = UPDATE_FAST_CYC_DEF,
  parameter int unsigned UPDATE_SLOW_CYC = UPDATE_SLOW_CYC_DEF
) (
  input  wire logic     core_clk,
  input  wire logic     rstn,
  input  wire logic     clkEn,
  input  wire logic     oscTick,
  input  wire logic     resetPinN,
  input  wire apb_req_t apbReq,
  output apb_rsp_t      apbRsp,
  input  wire time_t    timeNow,
  input  wire time_t    alarmTime,
  output cal_ctl_t      calCtl,
  output logic          irqN,
  output logic          sqwOut
);

  typedef struct packed {
    logic [1:0]           pinSync;
    logic [DIV_W-1:0]     div;
    logic [2:0]           divSel;
    logic [3:0]           rateSel;
    logic [7:0]           ctrl;
    logic                 pf;
    logic                 af;
    logic                 uf;
    logic                 tapPrev;
    upd_state_t           upd;
    logic [UPD_CNT_W-1:0] updCnt;
    logic                 advance;
    logic [7:0]           rdData;
    logic                 irqN;
    logic                 square_wave_out;
  } rtc_state_t;

  localparam rtc_state_t STATE_POR = '{
    pinSync: 2'h3, div: DIV_HALF, divSel: POR_DIVSEL, rateSel: POR_RATESEL,
    ctrl: POR_CTRL, pf: 1'b0, af: 1'b0, uf: 1'b0, tapPrev: 1'b0,
    upd: UPD_IDLE, updCnt: '0, advance: 1'b0, rdData: 8'h00,
    irqN: 1'b1, square_wave_out: 1'b0};

  rtc_state_t s_r;
  rtc_state_t s_nxt;

  function automatic logic [PADDR_W-1:0] byteAddr(input logic [7:0] idx);
    byteAddr = PADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic [4:0] tapIndex(input logic [3:0] rs, input logic [2:0] dv);
    if (dv == DIV_SLOW && rs < RATE_SPLIT) begin
      tapIndex = {1'b0, rs} + TAP_OFS_SLOW;
    end else begin
      tapIndex = {1'b0, rs} + TAP_OFS_FAST;
    end
  endfunction

  function automatic logic byteMatch(input logic [7:0] t, input logic [7:0] a);
    byteMatch = (a[7:6] == 2'b11) || (a == t);
  endfunction

  function automatic logic isRunCode(input logic [2:0] dv);
    isRunCode = (dv == DIV_FAST) || (dv == DIV_MID) || (dv == DIV_SLOW);
  endfunction

  logic                 setup;
  logic                 access;
  logic                 hitA;
  logic                 hitB;
  logic                 hitC;
  logic                 pinLow;
  logic                 tick1Hz;
  logic                 tapNow;
  logic                 pfSet;
  logic                 afSet;
  logic                 ufSet;
  logic [2:0]           flagClr;
  logic [DIV_W:0]       divSum;
  logic [DIV_W:0]       divStep;
  logic [UPD_CNT_W-1:0] updLen;
  logic [2:0]           enables;
  logic                 setRise;

  assign hitA   = apbReq.paddr == byteAddr(IDX_DIV_RATE);
  assign hitB   = apbReq.paddr == byteAddr(IDX_CTRL);
  assign hitC   = apbReq.paddr == byteAddr(IDX_FLAGS);
  assign setup  = apbReq.psel && !apbReq.penable;
  assign access = apbReq.psel && apbReq.penable;
  assign updLen = (s_r.divSel == DIV_SLOW) ? UPD_CNT_W'(UPDATE_SLOW_CYC - 1)
                                           : UPD_CNT_W'(UPDATE_FAST_CYC - 1);

  always_comb begin
    s_nxt   = s_r;
    pinLow  = !s_r.pinSync[1];
    tick1Hz = 1'b0;
    pfSet   = 1'b0;
    afSet   = 1'b0;
    ufSet   = 1'b0;
    flagClr = 3'h0;
    divSum  = '0;
    divStep = '0;
    setRise = 1'b0;
    s_nxt.pinSync = {s_r.pinSync[0], resetPinN};
    s_nxt.advance = 1'b0;

    // Register writes; control registers never wait for the update cycle
    if (access && apbReq.pwrite) begin
      if (hitA) begin
        s_nxt.divSel  = apbReq.pwdata[A_DIVSEL_LSB +: 3];
        s_nxt.rateSel = apbReq.pwdata[A_RATESEL_LSB +: 4];
      end
      if (hitB) begin
        setRise    = apbReq.pwdata[B_SET_BIT] && !s_r.ctrl[B_SET_BIT];
        s_nxt.ctrl = apbReq.pwdata[7:0];
        if (setRise) begin
          s_nxt.ctrl[B_UIE_BIT] = 1'b0;
        end
      end
    end

    // Read data is latched in the setup cycle so it holds steady through access
    if (setup) begin
      if (hitA) begin
        s_nxt.rdData = {s_r.upd != UPD_IDLE, s_r.divSel, s_r.rateSel};
      end else if (hitB) begin
        s_nxt.rdData = s_r.ctrl;
      end else if (hitC) begin
        s_nxt.rdData = {!s_r.irqN, s_r.pf, s_r.af, s_r.uf, 4'h0};
      end else begin
        s_nxt.rdData = 8'h00;
      end
    end
    if (access && !apbReq.pwrite && hitC) begin
      flagClr = s_r.rdData[C_FLAG_LSB +: 3];
    end

    // Divider chain advances only on oscillator ticks
    if (!isRunCode(s_nxt.divSel)) begin
      // Hold codes park the chain halfway so the first tick lands 0.5 s on
      if (s_nxt.divSel == DIV_HOLDA || s_nxt.divSel == DIV_HOLDB) begin
        s_nxt.div = DIV_HALF;
      end
    end else if (oscTick) begin
      case (s_nxt.divSel)
        DIV_FAST: divStep = (DIV_W+1)'(1) << BYPASS_FAST;
        DIV_MID:  divStep = (DIV_W+1)'(1) << BYPASS_MID;
        default:  divStep = (DIV_W+1)'(1) << BYPASS_SLOW;
      endcase
      divSum    = {1'b0, s_r.div} + divStep;
      s_nxt.div = divSum[DIV_W-1:0];
      tick1Hz   = divSum[DIV_W];
    end

    // Shared tap for periodic flag and square wave; falling edge marks a period
    tapNow        = s_nxt.div[tapIndex(s_nxt.rateSel, s_nxt.divSel)];
    s_nxt.tapPrev = tapNow;
    if (s_nxt.rateSel != 4'h0) begin
      pfSet = s_r.tapPrev && !tapNow;
    end
    s_nxt.square_wave_out = s_nxt.ctrl[B_SQUARE_WAVE_EN_BIT] && (s_nxt.rateSel != 4'h0) && tapNow;

    // Update sequence: pending window, then busy window
    if (s_nxt.ctrl[B_SET_BIT]) begin
      s_nxt.upd    = UPD_IDLE;
      s_nxt.updCnt = '0;
    end else begin
      case (s_r.upd)
        UPD_IDLE: begin
          if (tick1Hz) begin
            s_nxt.upd    = UPD_PENDING;
            s_nxt.updCnt = UPD_CNT_W'(PRE_UPDATE_CYC - 1);
          end
        end
        UPD_PENDING: begin
          if (s_r.updCnt == '0) begin
            s_nxt.upd     = UPD_BUSY;
            s_nxt.updCnt  = updLen;
            s_nxt.advance = 1'b1;
          end else begin
            s_nxt.updCnt = s_r.updCnt - 1'b1;
          end
        end
        UPD_BUSY: begin
          if (s_r.updCnt == '0) begin
            s_nxt.upd = UPD_IDLE;
            ufSet     = 1'b1;
            afSet     = byteMatch(timeNow.hours, alarmTime.hours) &&
                        byteMatch(timeNow.minutes, alarmTime.minutes) &&
                        byteMatch(timeNow.seconds, alarmTime.seconds);
          end else begin
            s_nxt.updCnt = s_r.updCnt - 1'b1;
          end
        end
        default: begin
          s_nxt.upd    = UPD_IDLE;
          s_nxt.updCnt = '0;
        end
      endcase
    end

    // A new event in the read-clear cycle survives the clear
    s_nxt.pf = (s_r.pf && !flagClr[2]) || pfSet;
    s_nxt.af = (s_r.af && !flagClr[1]) || afSet;
    s_nxt.uf = (s_r.uf && !flagClr[0]) || ufSet;

    // Reset pin clears enables, flags and the square-wave output; formats, set and selects survive
    if (pinLow) begin
      s_nxt.ctrl[B_PIE_BIT]  = 1'b0;
      s_nxt.ctrl[B_AIE_BIT]  = 1'b0;
      s_nxt.ctrl[B_UIE_BIT]  = 1'b0;
      s_nxt.ctrl[B_SQUARE_WAVE_EN_BIT] = 1'b0;
      s_nxt.square_wave_out = 1'b0;
      s_nxt.pf  = 1'b0;
      s_nxt.af  = 1'b0;
      s_nxt.uf  = 1'b0;
    end

    enables    = {s_nxt.ctrl[B_PIE_BIT], s_nxt.ctrl[B_AIE_BIT], s_nxt.ctrl[B_UIE_BIT]};
    s_nxt.irqN = !(|({s_nxt.pf, s_nxt.af, s_nxt.uf} & enables));

    if (!clkEn) begin
      s_nxt = s_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= STATE_POR;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero-wait slave; a frozen clock enable stretches the access phase
  assign apbRsp.pready  = apbReq.penable && clkEn;
  assign apbRsp.pslverr = access && !(hitA || hitB || hitC);
  assign apbRsp.prdata  = {24'h0, s_r.rdData};

  assign irqN   = s_r.irqN;
  assign sqwOut = s_r.square_wave_out;
  assign calCtl = '{advance:   s_r.advance,
                    binaryFmt: s_r.ctrl[B_BIN_BIT],
                    hour24:    s_r.ctrl[B_H24_BIT],
                    dstEn:     s_r.ctrl[B_DSE_BIT],
                    holdSet:   s_r.ctrl[B_SET_BIT]};

  // Helper: length of the pending window actually spent
  logic [UPD_CNT_W-1:0] pendLen;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pendLen <= '0;
    end else if (clkEn) begin
      if (s_r.upd == UPD_PENDING) begin
        pendLen <= pendLen + 1'b1;
      end else begin
        pendLen <= '0;
      end
    end
  end

  chk_pending_window: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.upd == UPD_BUSY && $past(s_r.upd) == UPD_PENDING) |->
      pendLen == UPD_CNT_W'(PRE_UPDATE_CYC))
    else $error("pending window length wrong");

  chk_busy_load: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.upd == UPD_BUSY && $past(s_r.upd) == UPD_PENDING) |->
      s_r.updCnt == updLen && s_r.advance)
    else $error("update duration not loaded");

  chk_hold_half: assert property (@(posedge core_clk) disable iff (!rstn)
    (clkEn && (s_r.divSel == DIV_HOLDA || s_r.divSel == DIV_HOLDB) &&
     !(apbReq.psel && apbReq.penable && apbReq.pwrite && hitA)) |=> s_r.div == DIV_HALF)
    else $error("divider not parked at half");

  chk_set_blocks: assert property (@(posedge core_clk) disable iff (!rstn)
    s_r.ctrl[B_SET_BIT] |-> s_r.upd == UPD_IDLE && !s_r.advance)
    else $error("update while set bit high");

  chk_set_clears_uie: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(s_r.ctrl[B_SET_BIT]) |-> !s_r.ctrl[B_UIE_BIT])
    else $error("update-end enable survived set");

  chk_sqw_gated: assert property (@(posedge core_clk) disable iff (!rstn)
    (!s_r.ctrl[B_SQUARE_WAVE_EN_BIT] || s_r.rateSel == 4'h0) |-> !sqwOut)
    else $error("square wave while disabled");

  chk_irq_summary: assert property (@(posedge core_clk) disable iff (!rstn)
    irqN == !((s_r.pf && s_r.ctrl[B_PIE_BIT]) || (s_r.af && s_r.ctrl[B_AIE_BIT]) ||
              (s_r.uf && s_r.ctrl[B_UIE_BIT])))
    else $error("interrupt output disagrees with flags");

  chk_update_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.upd == UPD_BUSY && s_r.updCnt == '0 && clkEn && !s_nxt.ctrl[B_SET_BIT] &&
     s_r.pinSync[1]) |=> s_r.uf)
    else $error("update-done flag missing");

  chk_read_clears: assert property (@(posedge core_clk) disable iff (!rstn)
    (access && !apbReq.pwrite && hitC && clkEn && !ufSet && !afSet && !pfSet) |=>
      (({s_r.pf, s_r.af, s_r.uf} & $past(s_r.rdData[6:4])) == 3'h0))
    else $error("flag survived read");

  chk_pending_bit: assert property (@(posedge core_clk) disable iff (!rstn)
    (setup && hitA && clkEn && s_r.upd != UPD_IDLE) |=> s_r.rdData[A_PENDING_BIT])
    else $error("pending bit not reported");

  cov_full_update: cover property (@(posedge core_clk) disable iff (!rstn)
    s_r.upd == UPD_BUSY ##1 s_r.upd == UPD_IDLE);
  cov_periodic: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(s_r.pf) && s_r.ctrl[B_PIE_BIT]);
  cov_set_abort: cover property (@(posedge core_clk) disable iff (!rstn)
    s_r.upd == UPD_BUSY ##1 s_r.ctrl[B_SET_BIT]);
  cov_alarm: cover property (@(posedge core_clk) disable iff (!rstn)
    $rose(s_r.af));

endmodule

// File: rtc_time_source.sv
// Oscillator and calendar stand-in facing the divider and control block
`timescale 1ns/1ps
module rtc_time_source
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_DIV = 1
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic advance,
  output logic      oscTick,
  output time_t     timeNow
);
  int unsigned divCnt;

  // The oscillator is a one-cycle enable every TICK_DIV system clocks, never a clock of its own
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt  <= 0;
      oscTick <= 1'b0;
      timeNow <= '0;
    end else begin
      divCnt  <= (divCnt + 1 >= TICK_DIV) ? 0 : divCnt + 1;
      oscTick <= (divCnt + 1 >= TICK_DIV);
      if (advance) begin
        timeNow.seconds <= timeNow.seconds + 8'h01;
      end
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the divider, rate and control block
`timescale 1ns/1ps
module tb;
  import rtc_pkg::*;
  localparam int PRE  = 8;
  localparam int UPS  = 20;
  // Half a second of slow-base ticks, with one oscillator tick per clock
  localparam int HALF = 16384;
  logic       core_clk;
  logic       rstn;
  logic       resetPinN;
  logic       oscTick;
  apb_req_t   req;
  apb_rsp_t   rsp;
  time_t      timeNow;
  time_t      alarmTime;
  cal_ctl_t   calCtl;
  logic       irqN;
  logic       sqwOut;
  logic [7:0] rd;
  logic       err;
  logic [7:0] hi;
  int         miscompares;
  int         cmp_count;
  int         cyc;
  int         t0;

  rtc_divider_rate_and_control #(
    .PRE_UPDATE_CYC  (PRE),
    .UPDATE_FAST_CYC (10),
    .UPDATE_SLOW_CYC (UPS)
  ) i_rtc_divider_rate_and_control (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .clkEn     (1'b1),
    .oscTick   (oscTick),
    .resetPinN (resetPinN),
    .apbReq    (req),
    .apbRsp    (rsp),
    .timeNow   (timeNow),
    .alarmTime (alarmTime),
    .calCtl    (calCtl),
    .irqN      (irqN),
    .sqwOut    (sqwOut)
  );

  rtc_time_source #(.TICK_DIV(1)) i_rtc_time_source (
    .core_clk (core_clk),
    .rstn     (rstn),
    .advance  (calCtl.advance),
    .oscTick  (oscTick),
    .timeNow  (timeNow)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("unexpected %s expected event seen timeout", what);
    stop_test();
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Request held until pready is sampled high; an idle cycle follows every transfer
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx[5:0], 2'b00}, pwdata: {24'h0, wd}};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) hang("pready");
    rd = rsp.prdata[7:0];
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk8(what, exp, rd);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irqN !== 1'b0 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 400) hang("interrupt");
  endtask

  task automatic sqw_count();
    hi = 8'h00;
    wait_cyc(3);
    repeat (16) begin
      @(posedge core_clk);
      hi += {7'h0, sqwOut};
    end
  endtask

  task automatic t_reset_vals();
    rdchk("divider rate reg", IDX_DIV_RATE, 8'h60);
    rdchk("control reg", IDX_CTRL, 8'h80);
    rdchk("flag reg", IDX_FLAGS, 8'h00);
    apb(1'b0, 8'h0d, 8'h00);
    chk1("unmapped error", 1'b1, err);
    chk8("unmapped data", 8'h00, rd);
    wr(IDX_FLAGS, 8'hff);
    rdchk("flag reg after write", IDX_FLAGS, 8'h00);
  endtask

  task automatic t_control();
    wr(IDX_DIV_RATE, 8'he6);
    rdchk("pending bit write", IDX_DIV_RATE, 8'h66);
    wr(IDX_CTRL, 8'h7f);
    rdchk("control bits", IDX_CTRL, 8'h7f);
    chk8("format levels", 8'h0e, {4'h0, calCtl[3:0]});
    resetPinN <= 1'b0;
    wait_cyc(4);
    resetPinN <= 1'b1;
    wait_cyc(3);
    rdchk("control after pin", IDX_CTRL, 8'h07);
    rdchk("divider after pin", IDX_DIV_RATE, 8'h66);
    chk8("format after pin", 8'h0e, {4'h0, calCtl[3:0]});
  endtask

  task automatic t_periodic();
    wr(IDX_CTRL, 8'h00);
    wr(IDX_DIV_RATE, 8'h23);
    t0 = cyc;
    wait_cyc(20);
    chk1("irq with enable off", 1'b1, irqN);
    rdchk("periodic flag", IDX_FLAGS, 8'h40);
    wr(IDX_CTRL, 8'h40);
    wait_cyc(6);
    chk1("irq with enable on", 1'b0, irqN);
    wr(IDX_DIV_RATE, 8'h20);
    rdchk("summary and periodic", IDX_FLAGS, 8'hc0);
    rdchk("flags after read", IDX_FLAGS, 8'h00);
    chk1("irq after read", 1'b1, irqN);
    wr(IDX_CTRL, 8'h08);
    wr(IDX_DIV_RATE, 8'h23);
    sqw_count();
    chk8("sqw high count", 8'h08, hi);
    wr(IDX_DIV_RATE, 8'h20);
    sqw_count();
    chk8("sqw with rate off", 8'h00, hi);
  endtask

  // The first event after a rate change may be short, so the second gap is timed
  task automatic t_period(input logic [3:0] rate, input int exp);
    int ta;
    wr(IDX_CTRL, 8'h40);
    wr(IDX_DIV_RATE, {4'h2, rate});
    wait_irq();
    apb(1'b0, IDX_FLAGS, 8'h00);
    wait_irq();
    ta = cyc;
    apb(1'b0, IDX_FLAGS, 8'h00);
    wait_irq();
    chk1("periodic interval", 1'b1, (cyc - ta) == exp);
    apb(1'b0, IDX_FLAGS, 8'h00);
  endtask

  task automatic t_update();
    int tp;
    int ta;
    int n;
    tp = 0;
    ta = 0;
    n = 0;
    wr(IDX_CTRL, 8'h00);
    wr(IDX_DIV_RATE, 8'h20);
    // Polls finish well inside the pre-update window
    while (tp == 0 && n < 8000) begin
      apb(1'b0, IDX_DIV_RATE, 8'h00);
      if (rd[7] === 1'b1) tp = cyc;
      n++;
    end
    if (tp == 0) hang("update pending");
    n = 0;
    while (calCtl.advance !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40) hang("advance");
    ta = cyc;
    chk1("pending lead", 1'b1, ta >= tp && ta - tp <= PRE);
    chk1("first update delay", 1'b1,
         ta - t0 >= HALF + PRE - 2 && ta - t0 <= HALF + PRE + 3);
    rdchk("pending in busy", IDX_DIV_RATE, 8'ha0);
    rdchk("flags in busy", IDX_FLAGS, 8'h00);
    wait_cyc(UPS);
    rdchk("flags after update", IDX_FLAGS, 8'h30);
    rdchk("pending after update", IDX_DIV_RATE, 8'h20);
    chk8("seconds advanced", 8'h01, timeNow.seconds);
  endtask

  task automatic t_set_hold();
    logic seen;
    seen = 1'b0;
    wr(IDX_CTRL, 8'h10);
    // Set bit raised with the update-end enable on, then held for over one second of slow-base ticks
    wr(IDX_CTRL, 8'h90);
    rdchk("update end enable on set", IDX_CTRL, 8'h80);
    repeat (2 * HALF + 100) begin
      @(posedge core_clk);
      if (calCtl.advance === 1'b1) seen = 1'b1;
    end
    chk1("advance while set", 1'b0, seen);
    rdchk("flags while set", IDX_FLAGS, 8'h00);
  endtask

  initial begin
    miscompares = 0;
    cmp_count = 0;
    cyc = 0;
    t0 = 0;
    rstn = 1'b0;
    resetPinN = 1'b1;
    alarmTime = 24'hc0c0c0;
    req = '0;
    wait_cyc(3);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_reset_vals();
    t_control();
    t_periodic();
    t_period(4'h1, 128);
    t_period(4'h4, 8);
    t_period(4'h5, 16);
    t_update();
    t_set_hold();
    stop_test();
  end
endmodule
